// ### inc/sbfp_params.svh
/*
 Constants of the SPI burst framing block: word layout, check pattern,
 command fields, error flag positions and watchdog scale.
 Assumes inclusion by bare name from every file that needs them.
*/
`ifndef SBFP_PARAMS_SVH
`define SBFP_PARAMS_SVH

// Word and command layout
`define SBFP_WORD_W    16
`define SBFP_RW_BIT    15
`define SBFP_ADDR_HI   14
`define SBFP_ADDR_LO   5
`define SBFP_CNT_HI    4
`define SBFP_CNT_LO    0

// Fixed words
`define SBFP_CHECK     16'hAAA8
`define SBFP_UNLOCK    16'hBA61

// Error flag positions
`define SBFP_ERR_CLK   2
`define SBFP_ERR_FRAME 1
`define SBFP_ERR_WORD  0
`define SBFP_ERR_NONE  3'h0

// Long frame and gap timing
`define SBFP_DRAM_LEN  16'h0080
`define SBFP_WD_SCALE  32768
`define SBFP_WD_CW     21

`endif

// ### inc/sbfp_pkg.sv
/*
 Types of the SPI burst framing block: protocol states and write targets.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sbfp_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_DATA = 2'b01,
      ST_DONE = 2'b10,
      ST_ERR  = 2'b11
   } sbfp_state_t;

   // Codes match the target-selection value so it maps straight across
   typedef enum logic [2:0] {
      TGT_REG    = 3'b000,
      TGT_CODE1  = 3'b001,
      TGT_CODE2  = 3'b010,
      TGT_CODE12 = 3'b011,
      TGT_DRAM   = 3'b100
   } sbfp_tgt_t;

endpackage

// ### inc/sbfp_link_if.sv
/*
 Carrier between the serial-clock front end and the system-clock core.
 Assumes word and mid_word are stable whenever the toggle has settled.
*/
`timescale 1ns/1ps
interface sbfp_link_if;
   logic        word_tgl;
   logic [15:0] word;
   logic        mid_word;
   logic [2:0]  err;
   logic        clr;

   modport link (output word_tgl, output word, output mid_word,
                 input err, input clr);
   modport core (input word_tgl, input word, input mid_word,
                 output err, output clr);
endinterface

// ### design/sbfp_link.sv
/*
 Serial front end on the SPI clock: shifts words in and the check word out.
 Assumes SPI mode 0 and that clr is held while chip select is released.
*/
`timescale 1ns/1ps
`include "sbfp_params.svh"
module sbfp_link (
   // Serial pins
   input  wire logic spi_sck,
   input  wire logic spi_mosi,
   output logic      miso_r,
   // Core side
   sbfp_link_if.link lk
);
   localparam logic [15:0] CHK = `SBFP_CHECK;

   logic [3:0]  cnt_r;
   logic [14:0] sh_r;
   logic [15:0] hold_r;
   logic        tgl_r;
   logic        mid_r;
   logic [2:0]  e1_r;
   logic [2:0]  e2_r;

   assign lk.word     = hold_r;
   assign lk.word_tgl = tgl_r;
   assign lk.mid_word = mid_r;

   always_ff @(posedge spi_sck or posedge lk.clr) begin
      if (lk.clr) begin
         cnt_r  <= 4'h0;
         sh_r   <= 15'h0000;
         hold_r <= 16'h0000;
         tgl_r  <= 1'b0;
         mid_r  <= 1'b0;
         e1_r   <= `SBFP_ERR_NONE;
         e2_r   <= `SBFP_ERR_NONE;
      end else begin
         cnt_r <= cnt_r + 4'h1;
         sh_r  <= {sh_r[13:0], spi_mosi};
         mid_r <= (cnt_r != 4'hF);
         e1_r  <= lk.err;
         e2_r  <= e1_r;
         if (cnt_r == 4'hF) begin
            hold_r <= {sh_r, spi_mosi};
            tgl_r  <= ~tgl_r;
         end
      end
   end

   // Check word out
   // Error bits lag by two serial edges; they go out after bit 3.
   always_ff @(negedge spi_sck or posedge lk.clr) begin
      if (lk.clr) begin
         miso_r <= CHK[15];
      end else if (cnt_r > 4'hC) begin
         miso_r <= e2_r[~cnt_r[1:0]];
      end else begin
         miso_r <= CHK[~cnt_r];
      end
   end
endmodule // sbfp_link

// ### design/sbfp_wdog.sv
/*
 Gap watchdog: expires after (wd + 1) * SCALE idle cycles of clk.
 Assumes run and restart come from logic on clk.
*/
`timescale 1ns/1ps
`include "sbfp_params.svh"
module sbfp_wdog #(
   parameter int SCALE = `SBFP_WD_SCALE
) (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       sys_rst,
   // Control
   input  wire logic       run,
   input  wire logic       restart,
   input  wire logic [4:0] wd,
   // Status
   output logic            expire_r
);
   localparam int CW = `SBFP_WD_CW;

   logic [CW-1:0] cnt_r;
   wire  [CW-1:0] lim = CW'((int'(wd) + 1) * SCALE - 1);
   wire           hit = (cnt_r == lim);

   always_ff @(posedge clk) begin
      if (sys_rst || !run || restart) begin
         cnt_r    <= '0;
         expire_r <= 1'b0;
      end else begin
         expire_r <= hit;
         cnt_r    <= hit ? '0 : cnt_r + CW'(1);
      end
   end

   AST_WD_LIMIT: assert property (@(posedge clk) disable iff (sys_rst)
      expire_r |-> ($past(cnt_r) == $past(lim)) && $past(run))
      else $error("watchdog expired before its limit");
endmodule // sbfp_wdog

// ### design/sbfp_top.sv
/*
 SPI burst framing core: command decode, burst addressing, gap and
 chip-select checks, long frames and the error state.
 Assumes an SPI master in mode 0, SCK slower than clk, chip select high
 for at least four clk cycles between frames.
*/
//
// Behaviour
// - A write frame is one command word plus data words, 2 to 32 words for a nonzero count.
// - MISO carries the check pattern in 15:3 and three error flags in 2:0.
// - Every 16-bit word travels most significant bit first.
// - Write command has bit 15 low, address 0..1023, count 0..31.
// - Data words go to consecutive addresses from the start address.
// - After the counted data words, return idle (framed mode: after select release) and await a command.
// - Gap mode: a gap longer than the watchdog time enters the error state.
// - Gap mode: zero count and zero address starts a long frame.
// - Selection 001: long frame fills code RAM one, length from its register.
// - Selection 010: long frame fills code RAM two, length from its register.
// - Selection 011: both code RAMs, same data, channel-one length.
// - Selection 100: both data RAMs from address 0, exactly 128 words.
// - Other selection values: the zero command is ignored in gap mode.
// - Framed mode: first word after select is command, the rest data.
// - Framed mode, nonzero count: early release of select is an error.
// - Framed mode, nonzero count: extra data words are an error.
// - Framed mode, zero count: data runs until chip select is released.
// - Mode bit low selects gap mode, high selects framed mode.
// - Gap limit is (watchdog field + 1) times 32768 system clocks.
// - Command address sits in bits 14:5, count in bits 4:0.
// - In error state only 0xBA61 is accepted; it clears the error unless the clock-missing input is still set.
`timescale 1ns/1ps
`include "sbfp_params.svh"
module sbfp_top #(
   parameter int LEN_W    = 16,
   parameter int WD_SCALE = `SBFP_WD_SCALE
) (
   // System clock and reset
   input  wire logic             clk,
   input  wire logic             sys_rst,
   // SPI pins
   input  wire logic             spi_sck,
   input  wire logic             spi_cs_n,
   input  wire logic             spi_mosi,
   output logic                  spi_miso,
   // Configuration
   input  wire logic             cfg_mode_b,
   input  wire logic [4:0]       cfg_wdog,
   input  wire logic [2:0]       sel_value,
   input  wire logic [LEN_W-1:0] code_len1,
   input  wire logic [LEN_W-1:0] code_len2,
   input  wire logic             cksys_missing,
   // Write port
   output logic                  wr_en,
   output sbfp_pkg::sbfp_tgt_t   wr_tgt,
   output logic [9:0]            wr_addr,
   output logic [15:0]           wr_data,
   // Status
   output logic [2:0]            err_flags,
   output logic                  busy
);
   sbfp_link_if lk ();

   sbfp_pkg::sbfp_state_t state_r;
   sbfp_pkg::sbfp_state_t state_nxt;
   sbfp_pkg::sbfp_tgt_t   tgt_r;
   sbfp_pkg::sbfp_tgt_t   tgt_nxt;
   logic [LEN_W-1:0]      rem_r;
   logic [LEN_W-1:0]      rem_nxt;
   logic [9:0]            addr_r;
   logic [9:0]            addr_nxt;
   logic                  unb_r;
   logic                  unb_nxt;
   logic                  rd_r;
   logic                  rd_nxt;
   logic [2:0]            err_r;
   logic [2:0]            err_nxt;
   logic                  wr_nxt;
   logic                  cs_s1;
   logic                  cs_s2;
   logic                  cs_d_r;
   logic                  mid_s1;
   logic                  mid_s2;
   logic                  tg_s1;
   logic                  tg_s2;
   logic                  tg_d_r;
   logic                  ck_s1;
   logic                  ck_s2;
   logic                  clr_r;
   logic                  wd_exp;

   // Whole words only
   // Clearing the front end flips its toggle back; that edge is masked.
   wire word_stb = (tg_s2 ^ tg_d_r) & ~clr_r;
   // Gap watchdog only in gap mode
   wire gap_run  = (state_r == sbfp_pkg::ST_DATA) && !cfg_mode_b;

   sbfp_link u_link (
      .spi_sck  (spi_sck),
      .spi_mosi (spi_mosi),
      .miso_r   (spi_miso),
      .lk       (lk.link)
   );

   sbfp_wdog #(.SCALE(WD_SCALE)) u_wdog (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .run      (gap_run),
      .restart  (word_stb),
      .wd       (cfg_wdog),
      .expire_r (wd_exp)
   );

   assign lk.err = err_r;
   assign lk.clr = clr_r;

   // Pin crossings
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         {cs_s1, cs_s2, cs_d_r}  <= 3'h7;
         {mid_s1, mid_s2}        <= 2'h0;
         {tg_s1, tg_s2, tg_d_r}  <= 3'h0;
         {ck_s1, ck_s2}          <= 2'h0;
         clr_r                   <= 1'b1;
      end else begin
         cs_s1  <= spi_cs_n;
         cs_s2  <= cs_s1;
         cs_d_r <= cs_s2;
         mid_s1 <= lk.mid_word;
         mid_s2 <= mid_s1;
         tg_s1  <= lk.word_tgl;
         tg_s2  <= tg_s1;
         tg_d_r <= tg_s2;
         ck_s1  <= cksys_missing;
         ck_s2  <= ck_s1;
         // Front end held clear once the released select has been checked
         clr_r  <= cs_s2 & cs_d_r;
      end
   end

   wire cs_rise  = cs_s2 & ~cs_d_r;

   wire [15:0] w        = lk.word;
   wire        cmd_rd   = w[`SBFP_RW_BIT];
   wire [9:0]  cmd_addr = w[`SBFP_ADDR_HI:`SBFP_ADDR_LO];
   wire [4:0]  cmd_cnt  = w[`SBFP_CNT_HI:`SBFP_CNT_LO];
   wire        cnt_zero = (cmd_cnt == 5'h00);
   wire        zero_cmd = cnt_zero && (cmd_addr == 10'h000);
   wire        unlock   = (w == `SBFP_UNLOCK);

   wire sel_ok = (sel_value >= 3'h1) && (sel_value <= 3'h4);
   wire [LEN_W-1:0] long_len =
      (sel_value == sbfp_pkg::TGT_CODE2) ? code_len2 :
      (sel_value == sbfp_pkg::TGT_DRAM)  ? LEN_W'(`SBFP_DRAM_LEN) :
                                           code_len1;

   wire err_frame = (gap_run && wd_exp) ||
                    ((state_r == sbfp_pkg::ST_DATA) && cfg_mode_b &&
                     cs_rise && !unb_r) ||
                    ((state_r == sbfp_pkg::ST_DONE) && word_stb);
   wire [2:0] err_new = {ck_s2, err_frame, cs_rise & mid_s2};
   // Errors are latched: once in the error state later ones are dropped
   wire err_hit = (|err_new) && (state_r != sbfp_pkg::ST_ERR);

   always_comb begin
      state_nxt = state_r;
      tgt_nxt   = tgt_r;
      rem_nxt   = rem_r;
      addr_nxt  = addr_r;
      unb_nxt   = unb_r;
      rd_nxt    = rd_r;
      err_nxt   = err_r;
      wr_nxt    = 1'b0;
      case (state_r)
         sbfp_pkg::ST_IDLE: begin
            if (word_stb) begin
               if (zero_cmd && !cfg_mode_b) begin
                  if (sel_ok && (long_len != '0)) begin
                     state_nxt = sbfp_pkg::ST_DATA;
                     tgt_nxt   = sbfp_pkg::sbfp_tgt_t'(sel_value);
                     rem_nxt   = long_len;
                     addr_nxt  = 10'h000;
                     unb_nxt   = 1'b0;
                     rd_nxt    = 1'b0;
                  end
               end else if (!(cnt_zero && !cfg_mode_b)) begin
                  // Gap-mode zero count with an address is dropped
                  state_nxt = sbfp_pkg::ST_DATA;
                  tgt_nxt   = sbfp_pkg::TGT_REG;
                  rem_nxt   = LEN_W'(cmd_cnt);
                  addr_nxt  = cmd_addr;
                  unb_nxt   = cnt_zero;
                  rd_nxt    = cmd_rd;
               end
            end
         end
         sbfp_pkg::ST_DATA: begin
            if (word_stb) begin
               wr_nxt   = ~rd_r;
               addr_nxt = addr_r + 10'h001;
               if (!unb_r) begin
                  rem_nxt = rem_r - LEN_W'(1);
                  if (rem_r == LEN_W'(1)) begin
                     state_nxt = cfg_mode_b ? sbfp_pkg::ST_DONE
                                            : sbfp_pkg::ST_IDLE;
                  end
               end
            end else if (cs_rise && unb_r) begin
               state_nxt = sbfp_pkg::ST_IDLE;
            end
         end
         sbfp_pkg::ST_DONE: begin
            if (cs_rise || !cfg_mode_b) begin
               state_nxt = sbfp_pkg::ST_IDLE;
            end
         end
         sbfp_pkg::ST_ERR: begin
            if (word_stb && unlock) begin
               if (ck_s2) begin
                  err_nxt = 3'h4;
               end else begin
                  state_nxt = sbfp_pkg::ST_IDLE;
                  err_nxt   = `SBFP_ERR_NONE;
               end
            end
         end
         default: begin
            state_nxt = sbfp_pkg::ST_IDLE;
         end
      endcase
      if (err_hit) begin
         state_nxt = sbfp_pkg::ST_ERR;
         err_nxt   = err_new;
         wr_nxt    = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_r <= sbfp_pkg::ST_IDLE;
         tgt_r   <= sbfp_pkg::TGT_REG;
         rem_r   <= '0;
         addr_r  <= 10'h000;
         unb_r   <= 1'b0;
         rd_r    <= 1'b0;
         err_r   <= `SBFP_ERR_NONE;
         busy    <= 1'b0;
      end else begin
         state_r <= state_nxt;
         tgt_r   <= tgt_nxt;
         rem_r   <= rem_nxt;
         addr_r  <= addr_nxt;
         unb_r   <= unb_nxt;
         rd_r    <= rd_nxt;
         err_r   <= err_nxt;
         busy    <= (state_nxt != sbfp_pkg::ST_IDLE);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_en   <= 1'b0;
         wr_tgt  <= sbfp_pkg::TGT_REG;
         wr_addr <= 10'h000;
         wr_data <= 16'h0000;
      end else begin
         wr_en <= wr_nxt;
         if (wr_nxt) begin
            wr_tgt  <= tgt_r;
            wr_addr <= addr_r;
            wr_data <= w;
         end
      end
   end

   assign err_flags = err_r;

   AST_ADDR_STEP: assert property (@(posedge clk) disable iff (sys_rst)
      wr_en |-> addr_r == 10'(wr_addr + 10'h001))
      else $error("burst address did not advance by one");

   AST_RET_IDLE: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_DATA && word_stb && !unb_r && !cfg_mode_b &&
       rem_r == LEN_W'(1) && !err_hit) |=> state_r == sbfp_pkg::ST_IDLE)
      else $error("no return to idle after last data word");

   AST_GAP_ERR: assert property (@(posedge clk) disable iff (sys_rst)
      (gap_run && wd_exp) |=> state_r == sbfp_pkg::ST_ERR && err_r[1])
      else $error("gap timeout did not enter error state");

   AST_LONG_IGN: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_IDLE && word_stb && zero_cmd && !cfg_mode_b &&
       !sel_ok && !err_hit) |=> state_r == sbfp_pkg::ST_IDLE ##1 !wr_en)
      else $error("zero command with bad selection not ignored");

   AST_LONG_LEN: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_IDLE && word_stb && zero_cmd && !cfg_mode_b &&
       sel_value == 3'h4 && !err_hit) |=>
      state_r == sbfp_pkg::ST_DATA && rem_r == LEN_W'(128) &&
      addr_r == 10'h000)
      else $error("data RAM long frame set up wrongly");

   AST_SHORT: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_DATA && cfg_mode_b && cs_rise && !unb_r)
      |=> state_r == sbfp_pkg::ST_ERR)
      else $error("early select release not flagged");

   AST_EXTRA: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_DONE && word_stb) |=>
      state_r == sbfp_pkg::ST_ERR ##1 !wr_en)
      else $error("extra data word not flagged");

   AST_ERR_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_ERR && !(word_stb && unlock)) |=>
      state_r == sbfp_pkg::ST_ERR && $stable(err_r) && !wr_en)
      else $error("error state left without unlock word");

   AST_UNLOCK: assert property (@(posedge clk) disable iff (sys_rst)
      (state_r == sbfp_pkg::ST_ERR && word_stb && unlock && !ck_s2) |=>
      state_r == sbfp_pkg::ST_IDLE && err_r == 3'h0)
      else $error("unlock word did not clear error");
endmodule // sbfp_top

// ### sim/sbfp_spi_master.sv
/*
 Behavioural SPI master, mode 0, driving the burst framing core.
 Assumes the bench calls one task at a time and nothing else drives pins.
*/
`timescale 1ns/1ps
module sbfp_spi_master (
   // Serial pins
   output logic      sck,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   initial begin
      sck  = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
   end
   task automatic open_frame();
      cs_n = 1'b0;
      #61;
   endtask
   // Released data line flips so a stale bit never passes for data
   task automatic close_frame();
      #7;
      cs_n = 1'b1;
      mosi = ~mosi;
      #53;
   endtask
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] r);
      r = 16'h0000;
      for (int i = 15; i > 15 - n; i--) begin
         mosi = w[i];
         #6 sck = 1'b1;
         r[i] = miso;
         #6 sck = 1'b0;
      end
   endtask
endmodule // sbfp_spi_master

// ### sim/spi_burst_frame_protocol_tb.sv
/*
 Self-checking bench for the SPI burst framing core.
 Assumes sbfp_top with a shortened gap scale and the master model.
*/
`timescale 1ns/1ps
`include "sbfp_params.svh"
module spi_burst_frame_protocol_tb;
   localparam int WDS = 4;
   logic                clk, sys_rst, spi_sck, spi_cs_n, spi_mosi;
   logic                spi_miso, cfg_mode_b, cksys_missing, wr_en, busy;
   logic [4:0]          cfg_wdog;
   logic [2:0]          sel_value, err_flags;
   logic [15:0]         code_len1, code_len2, wr_data;
   logic [9:0]          wr_addr;
   sbfp_pkg::sbfp_tgt_t wr_tgt;
   int                  mismatches, checks;
   logic [28:0]         seen [$];
   logic [15:0]         dq [$];

   sbfp_top #(.LEN_W(16), .WD_SCALE(WDS)) u_dut (
      .clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
      .cfg_mode_b(cfg_mode_b), .cfg_wdog(cfg_wdog),
      .sel_value(sel_value), .code_len1(code_len1),
      .code_len2(code_len2), .cksys_missing(cksys_missing),
      .wr_en(wr_en), .wr_tgt(wr_tgt), .wr_addr(wr_addr),
      .wr_data(wr_data), .err_flags(err_flags), .busy(busy));
   sbfp_spi_master u_m (
      .sck(spi_sck), .cs_n(spi_cs_n), .mosi(spi_mosi), .miso(spi_miso));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(negedge clk) begin
      if (wr_en === 1'b1) seen.push_back({wr_tgt, wr_addr, wr_data});
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("Mismatches %0d, checks %0d", mismatches, checks);
      if (mismatches == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Busy may stay up in error, so the wait is bounded
   task automatic settle();
      int n;
      n = 0;
      repeat (8) @(negedge clk);
      while (busy !== 1'b0 && n < 100) begin
         @(negedge clk);
         n++;
      end
   endtask
   task automatic frame(input logic [15:0] w [$], input bit per_cs,
                        input bit chk, input logic [2:0] e);
      logic [15:0] r;
      foreach (w[i]) begin
         if (per_cs || i == 0) u_m.open_frame();
         u_m.xfer(w[i], 16, r);
         if (chk) check(r, `SBFP_CHECK | {13'h0000, e});
         if (per_cs || i == w.size() - 1) u_m.close_frame();
      end
   endtask
   task automatic burst(input logic [15:0] c, input int n,
                        input logic [15:0] b, input bit per_cs);
      logic [15:0] w [$];
      dq.delete();
      for (int i = 0; i < n; i++) dq.push_back(b + 16'(i));
      w = dq;
      w.push_front(c);
      frame(w, per_cs, 1'b1, 3'h0);
      settle();
   endtask
   task automatic expect_wr(input logic [2:0] t, input logic [9:0] a,
                            input logic [15:0] d [$]);
      check(seen.size(), d.size());
      foreach (d[i]) begin
         if (i < seen.size()) check(seen[i], {t, a + 10'(i), d[i]});
      end
      seen.delete();
   endtask
   task automatic unlock(input bit chk, input logic [2:0] e);
      frame('{16'hBA61}, 1'b1, chk, e);
      settle();
      check({err_flags, busy}, 4'h0);
      seen.delete();
   endtask

   task automatic t_reset();
      check({wr_en, busy, err_flags, spi_miso}, 6'h01);
      check({wr_tgt, wr_addr, wr_data}, 32'h0000_0000);
   endtask
   task automatic t_mode_a();
      burst(16'h7FE1, 1, 16'h0004, 1'b1);
      expect_wr(3'h0, 10'h3FF, dq);
      burst(16'h3282, 2, 16'hA5F0, 1'b1);
      expect_wr(3'h0, 10'h194, dq);
      burst(16'h8021, 1, 16'h5555, 1'b1);
      check(seen.size(), 0);
      // Longest frame with select held throughout
      burst(16'h7C1F, 31, 16'h0F00, 1'b0);
      expect_wr(3'h0, 10'h3E0, dq);
      check(busy, 1'b0);
   endtask
   task automatic t_long();
      int n;
      for (int s = 0; s < 6; s++) begin
         @(negedge clk);
         sel_value = 3'(s);
         n = (s == 1 || s == 3) ? 3 : (s == 2) ? 2 : (s == 4) ? 128 : 0;
         // Zero count only with a zero address
         burst(16'h0000, n, 16'(s) << 12, 1'b1);
         expect_wr(3'(s), 10'h000, dq);
         if (n == 0) begin
            burst(16'h00E1, 1, 16'h7777, 1'b1);
            expect_wr(3'h0, 10'h007, dq);
         end
      end
   endtask
   task automatic t_gap();
      @(negedge clk);
      cfg_wdog = 5'h03;
      frame('{16'h0162}, 1'b1, 1'b1, 3'h0);
      check(err_flags, 3'h0);
      repeat (40) @(negedge clk);
      check(err_flags, 3'h2);
      frame('{16'h1234}, 1'b1, 1'b1, 3'h2);
      settle();
      check(seen.size(), 0);
      unlock(1'b1, 3'h2);
      cfg_wdog = 5'h1F;
   endtask
   task automatic t_mode_b();
      @(negedge clk);
      cfg_mode_b = 1'b1;
      // Framed write bursts: first with a zero count, then with a count of two
      burst(16'h0140, 3, 16'h2000, 1'b0);
      expect_wr(3'h0, 10'h00A, dq);
      burst(16'h0202, 2, 16'h3000, 1'b0);
      expect_wr(3'h0, 10'h010, dq);
   endtask
   task automatic t_b_err();
      logic [15:0] r;
      for (int k = 0; k < 3; k++) begin
         u_m.open_frame();
         u_m.xfer(k == 0 ? 16'h0202 : 16'h0201, 16, r);
         if (k == 1) u_m.xfer(16'h4321, 16, r);
         u_m.xfer(16'h1234, k == 2 ? 8 : 16, r);
         u_m.close_frame();
         settle();
         if (k == 2) begin
            check(seen.size(), 0);
            check(err_flags[0], 1'b1);
         end else begin
            check(err_flags, 3'h2);
         end
         unlock(1'b0, 3'h0);
      end
   endtask
   task automatic t_missing();
      @(negedge clk);
      cksys_missing = 1'b1;
      u_m.open_frame();
      repeat (10) @(negedge clk);
      check(err_flags, 3'h4);
      u_m.close_frame();
      @(negedge clk);
      cksys_missing = 1'b0;
      repeat (4) @(negedge clk);
      unlock(1'b1, 3'h4);
   endtask

   initial begin
      sys_rst       = 1'b1;
      cfg_mode_b    = 1'b0;
      cfg_wdog      = 5'h1F;
      sel_value     = 3'h0;
      code_len1     = 16'h0003;
      code_len2     = 16'h0002;
      cksys_missing = 1'b0;
      mismatches    = 0;
      checks        = 0;
      repeat (4) @(negedge clk);
      sys_rst = 1'b0;
      repeat (6) @(negedge clk);
      t_reset();
      t_mode_a();
      t_long();
      t_gap();
      t_mode_b();
      t_b_err();
      t_missing();
      report_and_stop();
   end
   // Whole run needs about 70 us; far beyond that means a hang
   initial begin
      #300000;
      mismatches++;
      report_and_stop();
   end
endmodule // spi_burst_frame_protocol_tb
